// File: rtl/fpf_pkg.sv
// Constants, code groups and register map for the fiber-capable coding block.
package fpf_pkg;
   // ----------------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------------
   localparam logic [7:0]  OFS_BASIC_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_PHY_CTRL     = 8'h04;
   localparam logic [7:0]  OFS_STATUS       = 8'h08;
   localparam logic [15:0] BASIC_CTRL_RST   = 16'h1100;
   localparam logic [15:0] PHY_CTRL_RST     = 16'h0000;
   localparam int          BCR_AN_EN_BIT    = 12;
   localparam int          BCR_DUPLEX_BIT   = 8;
   localparam int          BCR_FEF_DIS_BIT  = 2;
   localparam int          PCR_FEF_DIS_BIT  = 12;
   localparam int          PCR_MDIX_DIS_BIT = 10;
   localparam int          PCR_FLOW_EN_BIT  = 4;
   // ----------------------------------------------------------------------
   // Timing and line constants
   // ----------------------------------------------------------------------
   localparam int          BIT_DIV_DEF      = 1;
   localparam logic [6:0]  FEF_ONES         = 7'h54;
   localparam logic [10:0] LFSR_SEED        = 11'h7_FF;
   localparam logic [3:0]  LOCK_BITS        = 4'hB;
   // ----------------------------------------------------------------------
   // Code groups
   // ----------------------------------------------------------------------
   localparam logic [4:0]  SYM_IDLE         = 5'h1F;
   localparam logic [4:0]  SYM_J            = 5'h18;
   localparam logic [4:0]  SYM_K            = 5'h11;
   localparam logic [4:0]  SYM_T            = 5'h0D;
   localparam logic [4:0]  SYM_R            = 5'h07;
   localparam logic [9:0]  SYM_JK           = 10'h311;

   typedef enum logic [2:0] {TX_IDLE, TX_J, TX_K, TX_DATA, TX_T} fpf_tx_t;

   function automatic logic [4:0] enc_4b5b(input logic [3:0] n);
      logic [4:0] c;
      c = 5'h1E;
      unique case (n)
         4'h0: c = 5'h1E;  4'h1: c = 5'h09;  4'h2: c = 5'h14;  4'h3: c = 5'h15;
         4'h4: c = 5'h0A;  4'h5: c = 5'h0B;  4'h6: c = 5'h0E;  4'h7: c = 5'h0F;
         4'h8: c = 5'h12;  4'h9: c = 5'h13;  4'hA: c = 5'h16;  4'hB: c = 5'h17;
         4'hC: c = 5'h1A;  4'hD: c = 5'h1B;  4'hE: c = 5'h1C;  4'hF: c = 5'h1D;
      endcase
      return c;
   endfunction : enc_4b5b

   // Returns {valid, nibble}; any group outside the data set is invalid.
   function automatic logic [4:0] dec_4b5b(input logic [4:0] c);
      logic [4:0] r;
      r = 5'h00;
      for (int i = 0; i < 16; i++) begin
         if (enc_4b5b(4'(i)) == c) begin
            r = {1'b1, 4'(i)};
         end
      end
      return r;
   endfunction : dec_4b5b
endpackage : fpf_pkg

// File: rtl/fpf_pcs.sv
// Fast Ethernet coding chain with fiber bypass and far-end-fault handling.
//
// Contract
// - Transmit: serialise, 4B/5B code, scramble, NRZ to NRZI, then MLT3.
// - MAC nibbles leave as a serial stream, one bit per bit slot.
// - Receive: MLT3 to NRZI, recover, NRZI to NRZ, descramble, decode.
// - Bit timing is recovered from NRZI transitions and drives NRZ conversion.
// - Descrambled stream is 4B/5B decoded and handed to MAC as nibbles.
// - Scrambler is an eleven-bit linear feedback shift register.
// - Scrambler sequence repeats only after 2047 bits.
// - Descrambler uses the same sequence as the transmit scrambler.
// - Fiber mode bypasses scrambler, descrambler and MLT3 in both directions.
// - Fiber mode forces auto-negotiation off and crossover disabled.
// - Far-end fault raised when signal detect is false in fiber mode.
// - During fault, idle carries 84 ones then one zero, repeatedly.
// - Fault handling on after reset; either control bit disables it.
// - Signal detect decodes to no fiber, fiber with fault, fiber with signal.
// - Signal detect held high gives fiber mode and never a fault.
// - Short-wave fiber is forced: no negotiation, 100 Mbit/s, set duplex.
// - Forced fiber full duplex with flow control may send PAUSE frames.
// - Forced and negotiation settings live in the two port-1 registers.
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module fpf_pcs #(
   parameter int BIT_DIV = fpf_pkg::BIT_DIV_DEF
) (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   input  wire logic        tx_en,
   input  wire logic [3:0]  txd,
   output logic             tx_nibble_take,
   output logic             rx_dv,
   output logic      [3:0]  rxd,
   output logic             rx_nibble_valid,
   output logic             rx_code_err,
   input  wire logic        sd_above_low,
   input  wire logic        sd_above_high,
   input  wire logic        fiber_mode_select,
   input  wire logic        line_rx_fiber,
   input  wire logic        line_rx_pos,
   input  wire logic        line_rx_neg,
   output logic             line_tx_fiber,
   output logic             line_tx_pos,
   output logic             line_tx_neg,
   output logic             an_enable,
   output logic             mdix_enable,
   output logic             speed_100,
   output logic             full_duplex,
   output logic             pause_enable,
   output logic             far_end_fault
);
   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [5:0] pin_meta_reg;
   logic [5:0] pin_sync_reg;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         pin_meta_reg <= 6'h00;
         pin_sync_reg <= 6'h00;
      end else begin
         pin_meta_reg <= {sd_above_low, sd_above_high, fiber_mode_select,
                          line_rx_fiber, line_rx_pos, line_rx_neg};
         pin_sync_reg <= pin_meta_reg;
      end
   end
   wire sd_low_s  = pin_sync_reg[5];
   wire sd_high_s = pin_sync_reg[4];
   wire sel_s     = pin_sync_reg[3];
   wire rxf_s     = pin_sync_reg[2];
   wire rxp_s     = pin_sync_reg[1];
   wire rxn_s     = pin_sync_reg[0];

   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   logic [15:0] port1_basic_ctrl_reg;
   logic [15:0] port1_phy_ctrl_reg;
   logic [15:0] status_word;
   wire sel_bcr  = reg_addr == fpf_pkg::OFS_BASIC_CTRL;
   wire sel_pcr  = reg_addr == fpf_pkg::OFS_PHY_CTRL;
   wire sel_stat = reg_addr == fpf_pkg::OFS_STATUS;
   wire [15:0] rd_mux = sel_bcr  ? port1_basic_ctrl_reg :
                        sel_pcr  ? port1_phy_ctrl_reg :
                        sel_stat ? status_word : 16'h0000;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         port1_basic_ctrl_reg <= fpf_pkg::BASIC_CTRL_RST;
         port1_phy_ctrl_reg   <= fpf_pkg::PHY_CTRL_RST;
         reg_rdata            <= 16'h0000;
      end else begin
         if (reg_wr && sel_bcr) port1_basic_ctrl_reg <= reg_wdata;
         if (reg_wr && sel_pcr) port1_phy_ctrl_reg <= reg_wdata;
         if (reg_rd) reg_rdata <= rd_mux;
      end
   end

   // ----------------------------------------------------------------------
   // Mode decode
   // ----------------------------------------------------------------------
   // The analog three-level detect arrives as two comparator outputs.
   wire fiber_active = sd_low_s;
   wire signal_ok    = sd_low_s & sd_high_s;
   wire sx_forced    = signal_ok & ~sel_s;
   wire fef_en = ~port1_basic_ctrl_reg[fpf_pkg::BCR_FEF_DIS_BIT] &
                 ~port1_phy_ctrl_reg[fpf_pkg::PCR_FEF_DIS_BIT];
   assign far_end_fault = fiber_active & ~signal_ok & fef_en;
   assign an_enable   = ~fiber_active &
                        port1_basic_ctrl_reg[fpf_pkg::BCR_AN_EN_BIT];
   assign mdix_enable = ~fiber_active &
                        ~port1_phy_ctrl_reg[fpf_pkg::PCR_MDIX_DIS_BIT];
   assign speed_100   = 1'b1;
   assign full_duplex = port1_basic_ctrl_reg[fpf_pkg::BCR_DUPLEX_BIT];
   assign pause_enable = full_duplex &
                         port1_phy_ctrl_reg[fpf_pkg::PCR_FLOW_EN_BIT];

   // ----------------------------------------------------------------------
   // Bit slot divider
   // ----------------------------------------------------------------------
   // At the default the bit rate equals the clock; the chip clocks this
   // block from the line rate, so no fractional divide is needed.
   logic [7:0] div_reg;
   wire bit_en = div_reg == 8'(BIT_DIV - 1);
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) div_reg <= 8'h00;
      else div_reg <= bit_en ? 8'h00 : div_reg + 8'h01;
   end

   // ----------------------------------------------------------------------
   // Transmit framing and 4B/5B coding
   // ----------------------------------------------------------------------
   fpf_pkg::fpf_tx_t tx_st_reg, tx_st_next;
   logic [4:0] sym_reg, sym_next;
   logic [2:0] bit_cnt_reg;
   logic       idle_sym_reg, idle_sym_next;
   logic       take_next;
   wire sym_load = bit_en && bit_cnt_reg == 3'h4;
   always_comb begin
      tx_st_next    = tx_st_reg;
      sym_next      = fpf_pkg::SYM_IDLE;
      idle_sym_next = 1'b0;
      take_next     = 1'b0;
      unique case (tx_st_reg)
         fpf_pkg::TX_IDLE: begin
            if (tx_en) begin
               sym_next   = fpf_pkg::SYM_J;
               tx_st_next = fpf_pkg::TX_J;
            end else begin
               idle_sym_next = 1'b1;
            end
         end
         fpf_pkg::TX_J: begin
            sym_next   = fpf_pkg::SYM_K;
            tx_st_next = fpf_pkg::TX_K;
         end
         fpf_pkg::TX_K, fpf_pkg::TX_DATA: begin
            if (tx_en) begin
               sym_next   = fpf_pkg::enc_4b5b(txd);
               take_next  = 1'b1;
               tx_st_next = fpf_pkg::TX_DATA;
            end else begin
               sym_next   = fpf_pkg::SYM_T;
               tx_st_next = fpf_pkg::TX_T;
            end
         end
         fpf_pkg::TX_T: begin
            sym_next   = fpf_pkg::SYM_R;
            tx_st_next = fpf_pkg::TX_IDLE;
         end
      endcase
   end
   assign tx_nibble_take = sym_load & take_next;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tx_st_reg    <= fpf_pkg::TX_IDLE;
         sym_reg      <= fpf_pkg::SYM_IDLE;
         idle_sym_reg <= 1'b1;
         bit_cnt_reg  <= 3'h0;
      end else if (bit_en) begin
         bit_cnt_reg <= sym_load ? 3'h0 : bit_cnt_reg + 3'h1;
         if (sym_load) begin
            tx_st_reg    <= tx_st_next;
            sym_reg      <= sym_next;
            idle_sym_reg <= idle_sym_next;
         end else begin
            sym_reg <= {sym_reg[3:0], 1'b0};
         end
      end
   end

   // ----------------------------------------------------------------------
   // Far-end-fault idle pattern
   // ----------------------------------------------------------------------
   logic [6:0] ones_cnt_reg;
   wire fef_zero = idle_sym_reg & far_end_fault &
                   ones_cnt_reg == fpf_pkg::FEF_ONES;
   wire nrz_bit  = sym_reg[4] & ~fef_zero;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) ones_cnt_reg <= 7'h00;
      else if (bit_en) begin
         if (!idle_sym_reg || !nrz_bit) ones_cnt_reg <= 7'h00;
         else if (ones_cnt_reg != fpf_pkg::FEF_ONES)
            ones_cnt_reg <= ones_cnt_reg + 7'h01;
      end
   end

   // ----------------------------------------------------------------------
   // Scrambler, NRZI and MLT3
   // ----------------------------------------------------------------------
   logic [10:0] tx_lfsr_reg;
   logic        nrzi_reg;
   logic [1:0]  mlt_ph_reg;
   wire tx_ks   = tx_lfsr_reg[10] ^ tx_lfsr_reg[8];
   wire scr_bit = fiber_active ? nrz_bit : nrz_bit ^ tx_ks;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         tx_lfsr_reg <= fpf_pkg::LFSR_SEED;
         nrzi_reg    <= 1'b0;
         mlt_ph_reg  <= 2'h0;
      end else if (bit_en) begin
         tx_lfsr_reg <= {tx_lfsr_reg[9:0], tx_ks};
         nrzi_reg    <= nrzi_reg ^ scr_bit;
         if (scr_bit) mlt_ph_reg <= mlt_ph_reg + 2'h1;
      end
   end
   assign line_tx_fiber = nrzi_reg;
   assign line_tx_pos   = ~fiber_active & mlt_ph_reg == 2'h1;
   assign line_tx_neg   = ~fiber_active & mlt_ph_reg == 2'h3;

   // ----------------------------------------------------------------------
   // Receive clock recovery and NRZI to NRZ
   // ----------------------------------------------------------------------
   logic [1:0] rx_lvl_prev_reg;
   logic [7:0] rc_cnt_reg;
   logic       trans_seen_reg;
   // MLT3 collapses to an NRZI level change test; fiber is NRZI already.
   wire [1:0] rx_lvl = fiber_active ? {1'b0, rxf_s} : {rxp_s, rxn_s};
   wire rx_trans  = rx_lvl != rx_lvl_prev_reg;
   wire rx_strobe = rc_cnt_reg == 8'(BIT_DIV / 2);
   wire rx_bit    = trans_seen_reg | rx_trans;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rx_lvl_prev_reg <= 2'h0;
         rc_cnt_reg      <= 8'h00;
         trans_seen_reg  <= 1'b0;
      end else begin
         rx_lvl_prev_reg <= rx_lvl;
         if (rx_trans || rc_cnt_reg == 8'(BIT_DIV - 1))
            rc_cnt_reg <= 8'h00;
         else
            rc_cnt_reg <= rc_cnt_reg + 8'h01;
         trans_seen_reg <= rx_strobe ? 1'b0 : rx_bit;
      end
   end

   // ----------------------------------------------------------------------
   // Descrambler
   // ----------------------------------------------------------------------
   // Locks on idle, which is all ones in clear. Eleven bits in a row must
   // match its own prediction, so line fill after reset cannot lock it.
   logic [10:0] rx_lfsr_reg;
   logic [3:0]  lock_cnt_reg;
   wire rx_locked = lock_cnt_reg == fpf_pkg::LOCK_BITS;
   wire rx_ks     = rx_lfsr_reg[10] ^ rx_lfsr_reg[8];
   wire ks_match  = rx_ks == ~rx_bit;
   wire desc_bit  = fiber_active ? rx_bit : rx_bit ^ rx_ks;

   // ----------------------------------------------------------------------
   // Receive alignment and 4B/5B decode
   // ----------------------------------------------------------------------
   logic [9:0] rx_hist_reg;
   logic [2:0] rx_bcnt_reg;
   logic       in_frame_reg;
   wire [9:0] hist_next = {rx_hist_reg[8:0], desc_bit};
   wire [4:0] dec       = fpf_pkg::dec_4b5b(hist_next[4:0]);
   wire sym_done  = rx_strobe & in_frame_reg & rx_bcnt_reg == 3'h4;
   wire is_end    = hist_next[4:0] == fpf_pkg::SYM_T;
   wire bad_sym   = sym_done & ~is_end & ~dec[4];
   wire rx_ready  = fiber_active | rx_locked;
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         rx_lfsr_reg     <= 11'h000;
         lock_cnt_reg    <= 4'h0;
         rx_hist_reg     <= 10'h000;
         rx_bcnt_reg     <= 3'h0;
         in_frame_reg    <= 1'b0;
         rx_dv           <= 1'b0;
         rxd             <= 4'h0;
         rx_nibble_valid <= 1'b0;
         rx_code_err     <= 1'b0;
      end else begin
         rx_nibble_valid <= 1'b0;
         rx_code_err     <= bad_sym;
         if (rx_strobe) begin
            if (!rx_locked) begin
               rx_lfsr_reg  <= {rx_lfsr_reg[9:0], ~rx_bit};
               lock_cnt_reg <= ks_match ? lock_cnt_reg + 4'h1 : 4'h0;
            end else begin
               rx_lfsr_reg <= {rx_lfsr_reg[9:0], rx_ks};
            end
            if (bad_sym) lock_cnt_reg <= 4'h0;
            rx_hist_reg <= hist_next;
            rx_bcnt_reg <= rx_bcnt_reg == 3'h4 ? 3'h0 : rx_bcnt_reg + 3'h1;
            if (!in_frame_reg && rx_ready &&
                hist_next == fpf_pkg::SYM_JK) begin
               in_frame_reg <= 1'b1;
               rx_bcnt_reg  <= 3'h0;
               rx_dv        <= 1'b1;
            end else if (sym_done) begin
               if (is_end || bad_sym) begin
                  in_frame_reg <= 1'b0;
                  rx_dv        <= 1'b0;
               end else begin
                  rxd             <= dec[3:0];
                  rx_nibble_valid <= 1'b1;
               end
            end
         end
      end
   end

   assign status_word = {10'h000, rx_dv, rx_ready, sx_forced,
                         far_end_fault, signal_ok, fiber_active};

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   a_lfsr_nonzero: assert property (tx_lfsr_reg != 11'h000)
      else $error("scrambler register reached the lock-up state");
   a_fef_zero_bit: assert property (bit_en && fef_zero |=> !nrzi_reg ==
      !$past(nrzi_reg) && ones_cnt_reg == 7'h00)
      else $error("far-end-fault zero not sent after 84 ones");
   a_fiber_no_an: assert property (fiber_active |-> !an_enable && !mdix_enable)
      else $error("negotiation or crossover on in fiber mode");
   a_fault_cause: assert property (far_end_fault |->
      fiber_active && !sd_high_s && fef_en)
      else $error("fault raised without its cause");
   a_fault_off_sig: assert property (signal_ok |-> !far_end_fault)
      else $error("fault raised while signal present");
   a_nrzi_toggle: assert property (bit_en && scr_bit |=>
      nrzi_reg != $past(nrzi_reg))
      else $error("NRZI failed to toggle on a one");
   a_mlt_levels: assert property (!(line_tx_pos && line_tx_neg))
      else $error("MLT3 drives both levels");
   a_take_order: assert property (tx_nibble_take |=>
      tx_st_reg == fpf_pkg::TX_DATA)
      else $error("nibble taken outside a frame");
   a_pause_duplex: assert property (pause_enable |-> full_duplex)
      else $error("pause enabled in half duplex");
   a_rd_latency: assert property (reg_rd && sel_stat |=>
      reg_rdata == $past(status_word))
      else $error("status read data wrong");
   a_bad_flag: assert property (bad_sym |=> rx_code_err && !rx_dv)
      else $error("invalid code group not flagged");

   c_frame_tx: cover property (tx_st_reg == fpf_pkg::TX_T);
   c_fef_zero: cover property (bit_en && fef_zero);
   c_rx_nibble: cover property (rx_nibble_valid);
   c_rx_locked: cover property ($rose(rx_locked));
endmodule : fpf_pcs

// File: dv/fpf_xcvr_model.sv
// Behavioural fiber transceiver and copper line that loop transmit to receive.
`timescale 1ns/1ps
module fpf_xcvr_model (
   input  wire logic       clk_sys,
   input  wire logic [1:0] sd_level,
   input  wire logic       line_tx_fiber,
   input  wire logic       line_tx_pos,
   input  wire logic       line_tx_neg,
   output logic            line_rx_fiber,
   output logic            line_rx_pos,
   output logic            line_rx_neg,
   output logic            sd_above_low,
   output logic            sd_above_high
);
   // ----------------------------------------------------------------------
   // Signal detect levels: 0 no fiber, 1 fiber without light, 2 signal.
   // ----------------------------------------------------------------------
   assign sd_above_low  = (sd_level != 2'h0);
   assign sd_above_high = (sd_level == 2'h2);
   initial begin
      line_rx_fiber = 1'b0;
      line_rx_pos   = 1'b0;
      line_rx_neg   = 1'b0;
   end
   // Without light the receiver output chatters, so stale data never shows.
   always @(posedge clk_sys) begin
      line_rx_fiber <= (sd_level == 2'h1) ? ~line_rx_fiber : line_tx_fiber;
      line_rx_pos   <= line_tx_pos;
      line_rx_neg   <= line_tx_neg;
   end
endmodule : fpf_xcvr_model

// File: dv/fast_ethernet_pcs_fiber_fef_tb_top.sv
// Self-checking bench for the coding block with a looped-back line.
`timescale 1ns/1ps
module fast_ethernet_pcs_fiber_fef_tb_top;
   logic        clk_sys, reset, reg_wr, reg_rd, tx_en, fiber_mode_select;
   logic [7:0]  reg_addr;
   logic [15:0] reg_wdata, reg_rdata, v;
   logic [3:0]  txd, rxd;
   logic [1:0]  sd_level;
   logic        take, rx_dv, rx_nv, rx_err, sd_lo, sd_hi, rf, rp, rn, tf, tp, tn;
   logic        an_enable, mdix_enable, speed_100, full_duplex, pause_enable;
   logic        far_end_fault;
   logic [3:0]  rxq[$];
   int          errors, n_compared, n_err;

   fpf_pcs DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .tx_en(tx_en), .txd(txd),
      .tx_nibble_take(take), .rx_dv(rx_dv), .rxd(rxd),
      .rx_nibble_valid(rx_nv), .rx_code_err(rx_err), .sd_above_low(sd_lo),
      .sd_above_high(sd_hi), .fiber_mode_select(fiber_mode_select),
      .line_rx_fiber(rf), .line_rx_pos(rp), .line_rx_neg(rn),
      .line_tx_fiber(tf), .line_tx_pos(tp), .line_tx_neg(tn),
      .an_enable(an_enable), .mdix_enable(mdix_enable),
      .speed_100(speed_100), .full_duplex(full_duplex),
      .pause_enable(pause_enable), .far_end_fault(far_end_fault));
   fpf_xcvr_model xcvr (.clk_sys(clk_sys), .sd_level(sd_level),
      .line_tx_fiber(tf), .line_tx_pos(tp), .line_tx_neg(tn),
      .line_rx_fiber(rf), .line_rx_pos(rp), .line_rx_neg(rn),
      .sd_above_low(sd_lo), .sd_above_high(sd_hi));

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
      repeat (3) @(posedge clk_sys);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
      @(posedge clk_sys);
      d = reg_rdata;
   endtask : rd
   task automatic mode(input logic [1:0] s, input logic sel);
      sd_level <= s;
      fiber_mode_select <= sel;
      repeat (6) @(posedge clk_sys);
   endtask : mode
   task automatic stop_test();
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   // Sampled on the falling edge, clear of the launching edge.
   always @(negedge clk_sys) begin
      if (rx_nv === 1'b1) rxq.push_back(rxd);
      if (rx_err === 1'b1) n_err++;
   end

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   // Sends eight nibbles through the looped line; each must come back.
   task automatic frame_loop();
      logic [3:0] pl [8];
      int k;
      pl = '{4'h5, 4'h5, 4'hD, 4'h0, 4'hF, 4'hA, 4'h3, 4'hC};
      rxq.delete();
      n_err = 0;
      txd <= pl[0];
      tx_en <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         k = 0;
         do begin
            @(negedge clk_sys);
            k++;
         end while (take !== 1'b1 && k < 100);
         check(16'(take), 16'h0001);
         @(posedge clk_sys);
         if (i < 7) txd <= pl[i + 1];
         else tx_en <= 1'b0;
      end
      repeat (200) @(posedge clk_sys);
      check(16'(rxq.size()), 16'h0008);
      check(16'(n_err), 16'h0000);
      check(16'(rx_dv), 16'h0000);
      for (int i = 0; i < rxq.size() && i < 8; i++)
         check(16'(rxq[i]), 16'(pl[i]));
   endtask : frame_loop
   // Counts NRZI toggles between held bits on the idle fiber line.
   task automatic fef_pattern(input logic on);
      logic p;
      int run, bad, seen;
      run = 0;
      bad = 0;
      seen = 0;
      @(negedge clk_sys);
      p = tf;
      repeat (400) begin
         @(negedge clk_sys);
         if (tf !== p) run++;
         else begin
            if (seen > 0 && run != 84) bad++;
            seen++;
            run = 0;
         end
         p = tf;
      end
      check(16'(bad), 16'h0000);
      check(16'(seen > 1), 16'(on));
   endtask : fef_pattern
   // Light lost mid-frame: the receiver sees idle inside the frame.
   task automatic lost_light();
      n_err = 0;
      txd <= 4'h6;
      tx_en <= 1'b1;
      repeat (40) @(posedge clk_sys);
      check(16'(rx_dv), 16'h0001);
      sd_level <= 2'h1;
      repeat (40) @(posedge clk_sys);
      tx_en <= 1'b0;
      repeat (40) @(posedge clk_sys);
      check(16'(n_err > 0), 16'h0001);
      check(16'(rx_dv), 16'h0000);
      sd_level <= 2'h2;
      repeat (6) @(posedge clk_sys);
   endtask : lost_light

   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      errors++;
      stop_test();
   end
   initial begin
      {reset, reg_wr, reg_rd, tx_en, reg_addr, reg_wdata, txd} = '0;
      reset = 1'b1;
      fiber_mode_select = 1'b1;
      sd_level = 2'h0;
      errors = 0;
      n_compared = 0;
      n_err = 0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (40) @(posedge clk_sys);
      rd(8'h00, v); check(v, 16'h1100);
      rd(8'h04, v); check(v, 16'h0000);
      rd(8'h20, v); check(v, 16'h0000);
      wr(8'h08, 16'hFFFF);
      rd(8'h08, v); check(16'(v[3:0]), 16'h0000);
      check(16'({an_enable, mdix_enable}), 16'h0003);
      frame_loop();
      mode(2'h2, 1'b0);
      check(16'({an_enable, mdix_enable, far_end_fault}), 16'h0000);
      check(16'({speed_100, tp, tn}), 16'h0004);
      rd(8'h08, v); check(16'(v[5:0]), 16'h001B);
      frame_loop();
      fef_pattern(1'b0);
      lost_light();
      wr(8'h04, 16'h0010);
      check(16'(pause_enable), 16'h0001);
      wr(8'h00, 16'h1000);
      check(16'({an_enable, full_duplex, pause_enable}), 16'h0000);
      wr(8'h00, 16'h1100);
      wr(8'h04, 16'h0000);
      mode(2'h1, 1'b1);
      check(16'(far_end_fault), 16'h0001);
      rd(8'h08, v); check(16'(v[2:0]), 16'h0005);
      fef_pattern(1'b1);
      wr(8'h00, 16'h1104);
      check(16'(far_end_fault), 16'h0000);
      fef_pattern(1'b0);
      wr(8'h00, 16'h1100);
      check(16'(far_end_fault), 16'h0001);
      wr(8'h04, 16'h1000);
      check(16'(far_end_fault), 16'h0000);
      wr(8'h04, 16'h0000);
      mode(2'h0, 1'b1);
      check(16'({far_end_fault, an_enable}), 16'h0001);
      stop_test();
   end
endmodule : fast_ethernet_pcs_fiber_fef_tb_top
